// ---- core/ssr_pkg.sv ----
// Purpose: Constants for the start-up sequencer and synchronous reset pulse block
// Assumes: One system clock at 40 MHz
// Notes: Times are kept in ps with derived cycle counts
package ssr_pkg;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // Least wait from global reset release to first logic cell clock edge
  localparam int unsigned RST_RECOVERY_PS = 25000;
  localparam int unsigned RST_RECOVERY_CYC_RAW = (RST_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] RST_RECOVERY_CYC = (RST_RECOVERY_CYC_RAW < 1) ? 4'h1 : RST_RECOVERY_CYC_RAW[3:0];
  // Flip-flop accepts a clock edge this soon after direct reset release
  localparam int unsigned DIRECT_RST_RECOVERY_PS = 200;
  localparam logic PULSE_Q_RESET = 1'b0;
  localparam logic LATCH_RESET = 1'b1;
  localparam logic [3:0] RECOVERY_CNT_RESET = 4'h0;

  typedef enum logic [3:0] {
    SSR_CONFIG = 4'b0001,
    SSR_ARMED  = 4'b0010,
    SSR_PULSE  = 4'b0100,
    SSR_ACTIVE = 4'b1000
  } ssr_state_e;
endpackage : ssr_pkg

// ---- core/ssr_startup.sv ----
// Purpose: Activation of the array after configuration and one clock-aligned global reset pulse
// Assumes: config_clock is sampled as a synchronous input; board pulls the reset line up
// Notes: reset line is modelled as in/out/enable; enable is low while driving
`timescale 1ns/1ps
`default_nettype none
module ssr_startup (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic config_clock,
  input wire logic config_in_progress_n,
  input wire logic config_done,
  input wire logic osc_bits_loaded,
  input wire logic chain_done_in,
  input wire logic global_reset_n_in,
  output logic global_reset_n_out,
  output logic global_reset_n_oe_n,
  output logic device_active,
  output logic storage_reset,
  output logic io_tristate,
  output logic io_pullup_en,
  output logic logic_eval_en,
  output logic osc_enable,
  output logic logic_cell_clk_en
);
  ssr_pkg::ssr_state_e state_q;
  ssr_pkg::ssr_state_e state_d;
  logic cfg_clk_q;
  logic cfg_clk_rise;
  logic latch_q;
  logic pulse_q;
  logic [3:0] recov_cnt_q;
  logic reset_low;

  // True while the array is still loading and must stay quiet
  function automatic logic in_config(input ssr_pkg::ssr_state_e s);
    return s == ssr_pkg::SSR_CONFIG;
  endfunction : in_config

  // Line level as seen by the chip: external pull-up unless our driver pulls low
  assign reset_low = ~global_reset_n_in;
  assign cfg_clk_rise = config_clock & ~cfg_clk_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_clk_q <= 1'b0;
    end else begin
      cfg_clk_q <= config_clock;
    end
  end

  // Activation only on a config clock rising edge once chain and device are done
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ssr_pkg::SSR_CONFIG: begin
        if (config_done && chain_done_in && cfg_clk_rise) begin
          state_d = ssr_pkg::SSR_ARMED;
        end
      end
      ssr_pkg::SSR_ARMED: begin
        if (pulse_q) begin
          state_d = ssr_pkg::SSR_PULSE;
        end
      end
      ssr_pkg::SSR_PULSE: begin
        if (!pulse_q) begin
          state_d = ssr_pkg::SSR_ACTIVE;
        end
      end
      ssr_pkg::SSR_ACTIVE: begin
        state_d = ssr_pkg::SSR_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ssr_pkg::SSR_CONFIG;
    end else begin
      state_q <= state_d;
    end
  end

  // Set-reset latch: set while strobe low, cleared by pulse flip-flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_q <= ssr_pkg::LATCH_RESET;
    end else if (!config_in_progress_n) begin
      latch_q <= 1'b1;
    end else if (pulse_q) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_q;
    end
  end

  // Pulse flip-flop: held low during configuration and by the low line
  // Only the armed state may load it, so a stray strobe later cannot pulse again
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_q <= ssr_pkg::PULSE_Q_RESET;
    end else if (in_config(state_q) || reset_low) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= latch_q & (state_q == ssr_pkg::SSR_ARMED);
    end
  end

  // Data level of the line driver; drops low on the first clock after reset and stays there, so only the enable moves after that
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      global_reset_n_out <= 1'b1;
    end else begin
      global_reset_n_out <= 1'b0;
    end
  end

  // Driver enabled for the one cycle in which the pulse flip-flop is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      global_reset_n_oe_n <= 1'b1;
    end else begin
      global_reset_n_oe_n <= ~(latch_q & ~pulse_q & (state_q == ssr_pkg::SSR_ARMED)
                               & ~reset_low);
    end
  end

  // Recovery count after line release before logic cells may be clocked
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      recov_cnt_q <= ssr_pkg::RECOVERY_CNT_RESET;
    end else if (reset_low || state_q != ssr_pkg::SSR_ACTIVE) begin
      recov_cnt_q <= ssr_pkg::RECOVERY_CNT_RESET;
    end else if (recov_cnt_q < ssr_pkg::RST_RECOVERY_CYC) begin
      recov_cnt_q <= recov_cnt_q + 4'h1;
    end
  end

  // Active flag, storage reset and I/O controls wake together on the activation edge; logic cell clocks wait for recovery
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      device_active <= 1'b0;
    end else begin
      device_active <= ~in_config(state_d);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      storage_reset <= 1'b1;
    end else begin
      storage_reset <= in_config(state_d);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_tristate <= 1'b1;
    end else begin
      io_tristate <= in_config(state_d);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_pullup_en <= 1'b1;
    end else begin
      io_pullup_en <= in_config(state_d);
    end
  end

  // Logic cells stay unclocked until the released line has had time to settle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      logic_cell_clk_en <= 1'b0;
    end else begin
      logic_cell_clk_en <= (state_q == ssr_pkg::SSR_ACTIVE) && !reset_low
                           && (recov_cnt_q >= ssr_pkg::RST_RECOVERY_CYC);
    end
  end

  // Combinational logic comes alive while configuration is still running
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      logic_eval_en <= 1'b0;
    end else begin
      logic_eval_en <= 1'b1;
    end
  end

  // Oscillator starts as soon as its own bits are in, and keeps running
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= osc_enable | osc_bits_loaded;
    end
  end
endmodule : ssr_startup
`default_nettype wire

// ---- tb/ssr_board.sv ----
// Purpose: board reset line; Assumes: pull-up; Notes: low only while driven
`timescale 1ns/1ps
`default_nettype none
module ssr_board (
  input wire logic drive_n,
  output logic line_n
);
  // Pulled up unless the driver is on
  assign line_n = drive_n;
endmodule : ssr_board
`default_nettype wire

// ---- tb/ssr_startup_props.sv ----
// Purpose: port checks; Assumes: one clock; Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module ssr_startup_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic config_clock,
  input wire logic osc_bits_loaded,
  input wire logic global_reset_n_oe_n,
  input wire logic device_active,
  input wire logic storage_reset,
  input wire logic io_tristate,
  input wire logic osc_enable,
  input wire logic global_reset_n_in,
  input wire logic logic_cell_clk_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_drive_next: assert property ($rose(device_active) |=> !global_reset_n_oe_n) else $error("drive");
  a_one_pulse: assert property ($fell(global_reset_n_oe_n) |=> global_reset_n_oe_n) else $error("long");
  a_no_repeat: assert property ($rose(global_reset_n_oe_n) |=> global_reset_n_oe_n[*8]) else $error("again");
  a_act_edge: assert property ($rose(device_active) |-> $past(config_clock) && !$past(config_clock, 2)) else $error("edge");
  a_hold_store: assert property (storage_reset == !device_active) else $error("store");
  a_float_io: assert property (io_tristate == !device_active) else $error("io");
  a_drive_when: assert property (!global_reset_n_oe_n |-> device_active) else $error("early");
  a_osc_run: assert property ($past(osc_bits_loaded) |-> osc_enable) else $error("osc");
  a_clk_recovery: assert property ($rose(global_reset_n_in) |-> !logic_cell_clk_en ##1 !logic_cell_clk_en) else $error("recovery");
  cover property ($rose(device_active));
  cover property ($fell(global_reset_n_oe_n));
  cover property ($rose(osc_enable));
endmodule : ssr_startup_props
bind ssr_startup ssr_startup_props u_chk (.*);
`default_nettype wire

// ---- tb/ssr_startup_tb.sv ----
// Purpose: start-up bench; Assumes: 40 MHz; Notes: driver queues, monitor pops
`timescale 1ns/1ps
`default_nettype none
module ssr_startup_tb;
  logic ref_clk = 1'h0, rst = 1'h1, config_clock = 1'h0, config_in_progress_n = 1'h0;
  logic config_done = 1'h0, osc_bits_loaded = 1'h0, chain_done_in = 1'h0;
  logic global_reset_n_in, global_reset_n_out, global_reset_n_oe_n, device_active, storage_reset;
  logic io_tristate, io_pullup_en, logic_eval_en, osc_enable, logic_cell_clk_en;
  logic [31:0] seed = 32'h3ad8_f4af;
  logic [9:0] exp_q[$];
  int mismatches = 0, total_checks = 0, cyc = 0;
  wire logic [9:0] seen = {device_active, io_tristate, io_pullup_en, storage_reset, global_reset_n_oe_n,
                           global_reset_n_in, global_reset_n_out, osc_enable, logic_eval_en, logic_cell_clk_en};
  always #12.5 ref_clk = ~ref_clk;
  ssr_startup u_ssr_startup (.*);
  ssr_board u_ssr_board (.drive_n(global_reset_n_oe_n), .line_n(global_reset_n_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic tick(input logic [9:0] ex, input logic rnd);
    seed = lfsr(seed);
    if (rnd) config_clock = seed[0];
    exp_q.push_back(ex);
    @(negedge ref_clk);
  endtask : tick
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 400) begin
      mismatches++;
      conclude();
    end
    #2;
    if (exp_q.size() > 0) begin
      total_checks++;
      if (seen !== exp_q[0]) begin
        mismatches++;
        $display("Error state expected %h seen %h", exp_q[0], seen);
      end
      void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'h0;
    osc_bits_loaded = 1'h1;
    tick(10'h1f6, 1'h0);
    repeat (16) tick(10'h1f6, 1'h1);
    config_in_progress_n = 1'h1;
    config_done = 1'h1;
    repeat (8) tick(10'h1f6, 1'h1);
    chain_done_in = 1'h1;
    config_clock = 1'h0;
    tick(10'h1f6, 1'h0);
    config_clock = 1'h1;
    tick(10'h236, 1'h0);
    tick(10'h206, 1'h0);
    tick(10'h236, 1'h0);
    repeat (2) tick(10'h236, 1'h1);
    repeat (22) tick(10'h237, 1'h1);
    @(negedge ref_clk);
    conclude();
  end
endmodule : ssr_startup_tb
`default_nettype wire
